// [src/tvs_pkg.sv]
// Package for the television trigger sequencer: register map, field layouts,
// reset values, sequencer states and timing constants.
// Assumes a single 10 MHz sample clock shared by the register port and the sequencer.
package tvs_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] TVS_OFS_CTRL = 8'h00;
   localparam logic [7:0] TVS_OFS_LEVEL = 8'h04;
   localparam logic [7:0] TVS_OFS_EVCOUNT = 8'h08;
   localparam logic [7:0] TVS_OFS_MINWIDTH = 8'h0C;
   localparam logic [7:0] TVS_OFS_INHIBIT = 8'h10;
   localparam logic [7:0] TVS_OFS_STATUS = 8'h14;
   localparam logic [7:0] TVS_OFS_EVPROGRESS = 8'h18;

   // Line mode field codes
   localparam logic [1:0] TVS_LINE_NONE = 2'h0;
   localparam logic [1:0] TVS_LINE_525 = 2'h1;
   localparam logic [1:0] TVS_LINE_626 = 2'h2;

   // Control register layout, bit 31 downward
   typedef struct packed {
      logic [22:0] unused;
      logic enable;              // bit 8
      logic [1:0] source_sel;    // bits 7:6
      logic trig_edge_falling;   // bit 5
      logic user_sync_positive;  // bit 4
      logic std_sync_positive;   // bit 3
      logic [1:0] line_mode;     // bits 2:1
      logic user_mode;           // bit 0
   } tvs_ctrl_t;

   localparam logic [31:0] TVS_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] TVS_CTRL_WMASK = 32'h0000_01FF;
   localparam logic [31:0] TVS_LEVEL_RESET = 32'h0000_0080;
   localparam logic [23:0] TVS_EVCOUNT_RESET = 24'h00_0001;
   localparam logic [26:0] TVS_MINWIDTH_RESET = 27'h000_0001;
   localparam logic [31:0] TVS_INHIBIT_RESET = 32'h0000_0000;

   // Timing
   localparam longint TVS_CLK_PERIOD_PS = 100000;
   localparam longint TVS_MIN_WIDTH_LO_PS = 5000;
   localparam longint TVS_MIN_WIDTH_HI_PS = 64'd9999999990000;
   localparam longint TVS_MIN_WIDTH_LO_CYC_RAW = (TVS_MIN_WIDTH_LO_PS + TVS_CLK_PERIOD_PS - 1) / TVS_CLK_PERIOD_PS;
   localparam longint TVS_MIN_WIDTH_LO_CYC = (TVS_MIN_WIDTH_LO_CYC_RAW < 1) ? 1 : TVS_MIN_WIDTH_LO_CYC_RAW;
   localparam longint TVS_MIN_WIDTH_HI_CYC = TVS_MIN_WIDTH_HI_PS / TVS_CLK_PERIOD_PS;
   localparam longint TVS_EVCOUNT_MIN = 1;
   localparam longint TVS_EVCOUNT_MAX = 16000000;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      TVS_ST_SEEK_SYNC = 4'b0001,
      TVS_ST_DELAY = 4'b0010,
      TVS_ST_EDGE = 4'b0100,
      TVS_ST_INHIBIT = 4'b1000
   } tvs_state_t;

endpackage : tvs_pkg

// [src/tvs_trigger_sequencer.sv]
// Television trigger sequencer: standard-mode vertical sync qualifier and
// user-defined arm / delay / edge trigger sequencer with a register port.
// Assumes channel samples arrive as digitised words on ref_clk and software
// writes the mode selection before the user-defined settings.
`timescale 1ns/1ps

module tvs_trigger_sequencer
   import tvs_pkg::*;
#(
   parameter int N_CHAN = 4,
   parameter int SAMPLE_W = 8,
   parameter longint MIN_WIDTH_MAX_CYC = TVS_MIN_WIDTH_HI_CYC,
   parameter longint EVCOUNT_MAX = TVS_EVCOUNT_MAX
) (
   input wire logic ref_clk, // Sample clock, 10 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic [N_CHAN-1:0][SAMPLE_W-1:0] chan_sample, // Digitised channel samples
   input wire logic [7:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [31:0] reg_rdata, // Read data, cycle after the strobe
   output logic trig_out, // One-cycle trigger pulse
   output logic armed_out, // Sequencer armed or delaying
   output logic std_vsync_qual_out // Qualified vertical sync in standard mode
);

   tvs_ctrl_t ctrl_reg;
   logic [SAMPLE_W-1:0] level_reg;
   logic [SAMPLE_W-1:0] band_reg;
   logic [23:0] ev_count_reg;
   logic [26:0] min_width_reg;
   logic [31:0] inhibit_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   tvs_state_t state_reg;
   tvs_state_t state_next;
   logic cmp_reg;
   logic cmp_d_reg;
   logic [26:0] width_reg;
   logic [23:0] ev_prog_reg;
   logic [31:0] inhibit_cnt_reg;
   logic trig_reg;
   logic armed_reg;
   logic std_qual_reg;

   // Register decode
   wire wr_ctrl = reg_wr && (reg_addr == TVS_OFS_CTRL);
   wire wr_level = reg_wr && (reg_addr == TVS_OFS_LEVEL);
   wire wr_evcount = reg_wr && (reg_addr == TVS_OFS_EVCOUNT);
   wire wr_minwidth = reg_wr && (reg_addr == TVS_OFS_MINWIDTH);
   wire wr_inhibit = reg_wr && (reg_addr == TVS_OFS_INHIBIT);
   // Out-of-range values are refused and the old setting stays
   wire evcount_ok = (reg_wdata >= 32'(TVS_EVCOUNT_MIN)) && (reg_wdata <= 32'(EVCOUNT_MAX));
   wire minwidth_ok = (reg_wdata >= 32'(TVS_MIN_WIDTH_LO_CYC)) && (reg_wdata <= 32'(MIN_WIDTH_MAX_CYC));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= tvs_ctrl_t'(TVS_CTRL_RESET);
         level_reg <= TVS_LEVEL_RESET[SAMPLE_W-1:0];
         band_reg <= '0;
         ev_count_reg <= TVS_EVCOUNT_RESET;
         min_width_reg <= TVS_MINWIDTH_RESET;
         inhibit_reg <= TVS_INHIBIT_RESET;
      end else begin
         if (wr_ctrl) ctrl_reg <= tvs_ctrl_t'(reg_wdata & TVS_CTRL_WMASK);
         if (wr_level) begin
            level_reg <= reg_wdata[SAMPLE_W-1:0];
            band_reg <= reg_wdata[SAMPLE_W+7:8];
         end
         if (wr_evcount && evcount_ok) ev_count_reg <= reg_wdata[23:0];
         if (wr_minwidth && minwidth_ok) min_width_reg <= reg_wdata[26:0];
         if (wr_inhibit) inhibit_reg <= reg_wdata;
      end
   end

   // Read mux; an unmapped address reads zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (reg_addr)
         TVS_OFS_CTRL: rdata_next = 32'(ctrl_reg);
         TVS_OFS_LEVEL: rdata_next = {16'h0000, 8'(band_reg), 8'(level_reg)};
         TVS_OFS_EVCOUNT: rdata_next = {8'h00, ev_count_reg};
         TVS_OFS_MINWIDTH: rdata_next = {5'h00, min_width_reg};
         TVS_OFS_INHIBIT: rdata_next = inhibit_reg;
         TVS_OFS_STATUS: rdata_next = {27'h000_0000, cmp_reg, state_reg};
         TVS_OFS_EVPROGRESS: rdata_next = {8'h00, ev_prog_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) rdata_reg <= 32'h0000_0000;
      else rdata_reg <= reg_rd ? rdata_next : 32'h0000_0000;
   end

   // Channel selection and level comparison with noise_reject_band
   wire [SAMPLE_W-1:0] sel_sample = chan_sample[ctrl_reg.source_sel];
   wire [SAMPLE_W:0] level_hi = {1'b0, level_reg} + {1'b0, band_reg};
   // Rises at or above level plus band, falls only below level, so noise inside the band cannot toggle it
   wire cmp_next = ({1'b0, sel_sample} >= level_hi) ? 1'b1 :
                   (sel_sample < level_reg) ? 1'b0 : cmp_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmp_reg <= 1'b0;
         cmp_d_reg <= 1'b0;
      end else begin
         cmp_reg <= cmp_next;
         cmp_d_reg <= cmp_reg;
      end
   end

   wire cmp_rise = cmp_reg && !cmp_d_reg;
   wire cmp_fall = !cmp_reg && cmp_d_reg;
   wire sync_act = ctrl_reg.user_sync_positive ? cmp_reg : !cmp_reg;
   wire sync_lead = ctrl_reg.user_sync_positive ? cmp_rise : cmp_fall;
   wire sel_edge = ctrl_reg.trig_edge_falling ? cmp_fall : cmp_rise;
   wire user_run = ctrl_reg.enable && ctrl_reg.user_mode;
   wire std_active = ctrl_reg.enable && !ctrl_reg.user_mode &&
                     ((ctrl_reg.line_mode == TVS_LINE_525) || (ctrl_reg.line_mode == TVS_LINE_626));
   wire std_qual_next = std_active && (ctrl_reg.std_sync_positive ? cmp_reg : !cmp_reg);

   wire width_ok = (width_reg >= min_width_reg);
   wire [23:0] ev_prog_inc = ev_prog_reg + 24'h00_0001;
   wire delay_done = sync_lead && (ev_prog_inc >= ev_count_reg);
   wire inhibit_done = (inhibit_cnt_reg >= inhibit_reg);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TVS_ST_SEEK_SYNC: if (sync_act && width_ok) state_next = TVS_ST_DELAY;
         TVS_ST_DELAY: if (delay_done) state_next = TVS_ST_EDGE;
         TVS_ST_EDGE: if (sel_edge) state_next = TVS_ST_INHIBIT;
         TVS_ST_INHIBIT: if (inhibit_done) state_next = TVS_ST_SEEK_SYNC;
         default: state_next = TVS_ST_SEEK_SYNC;
      endcase
      if (!user_run) state_next = TVS_ST_SEEK_SYNC;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) state_reg <= TVS_ST_SEEK_SYNC;
      else state_reg <= state_next;
   end

   // Width counter saturates so a very long pulse never wraps back below the minimum
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) width_reg <= '0;
      else if (!sync_act) width_reg <= '0;
      else if (width_reg != 27'h7FF_FFFF) width_reg <= width_reg + 27'h000_0001;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) ev_prog_reg <= '0;
      else if (state_reg == TVS_ST_DELAY && sync_lead) ev_prog_reg <= ev_prog_inc;
      else if (state_reg != TVS_ST_DELAY) ev_prog_reg <= '0;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) inhibit_cnt_reg <= '0;
      else if (state_reg == TVS_ST_INHIBIT) inhibit_cnt_reg <= inhibit_cnt_reg + 32'h0000_0001;
      else inhibit_cnt_reg <= '0;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         trig_reg <= 1'b0;
         armed_reg <= 1'b0;
         std_qual_reg <= 1'b0;
      end else begin
         trig_reg <= user_run && (state_reg == TVS_ST_EDGE) && sel_edge;
         armed_reg <= (state_next == TVS_ST_DELAY) || (state_next == TVS_ST_EDGE);
         std_qual_reg <= std_qual_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign trig_out = trig_reg;
   assign armed_out = armed_reg;
   assign std_vsync_qual_out = std_qual_reg;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_STD_POLARITY: assert property (
      (std_active && (cmp_reg == ctrl_reg.std_sync_positive)) |=> std_vsync_qual_out)
      else $error("standard sync not qualified at programmed polarity");

   AST_STD_MODES_ONLY: assert property (
      !std_active |=> !std_vsync_qual_out)
      else $error("standard sync qualified outside 525 or 626 mode");

   AST_POL_READBACK: assert property (
      (reg_rd && reg_addr == TVS_OFS_CTRL) |=> (reg_rdata[3] == $past(ctrl_reg.std_sync_positive)))
      else $error("polarity readback wrong");

   AST_ARM_POLARITY: assert property (
      (state_reg == TVS_ST_SEEK_SYNC && user_run ##1 state_reg == TVS_ST_DELAY) |-> $past(sync_act))
      else $error("armed on wrong polarity");

   AST_ARM_WIDTH: assert property (
      (state_reg == TVS_ST_SEEK_SYNC ##1 state_reg == TVS_ST_DELAY) |-> $past(width_reg) >= $past(min_width_reg))
      else $error("armed on a pulse shorter than the minimum");

   AST_WIDTH_RANGE: assert property (
      (min_width_reg >= 27'(TVS_MIN_WIDTH_LO_CYC)) && (min_width_reg <= 27'(MIN_WIDTH_MAX_CYC)))
      else $error("minimum width out of range");

   AST_DELAY_DONE: assert property (
      (user_run && state_reg == TVS_ST_DELAY && delay_done) |=> state_reg == TVS_ST_EDGE)
      else $error("delay count reached without moving to edge search");

   AST_EVCOUNT_REFUSE: assert property (
      (wr_evcount && !evcount_ok) |=> $stable(ev_count_reg))
      else $error("out of range event count accepted");

   AST_TRIG_CAUSE: assert property (
      trig_out |-> ($past(state_reg) == TVS_ST_EDGE && $past(sel_edge)) ##1 !trig_out)
      else $error("trigger without armed edge search or longer than one cycle");

   AST_READ_WINDOW: assert property (
      (reg_rd && reg_addr == TVS_OFS_EVCOUNT) |=> reg_rdata == {8'h00, $past(ev_count_reg)} ##1 ($past(reg_rd) ||
      reg_rdata == 32'h0000_0000))
      else $error("event count readback wrong");

   AST_RESTART: assert property (
      trig_out |-> (state_reg == TVS_ST_INHIBIT) && (ev_prog_reg == 24'h00_0000))
      else $error("sequencer did not restart after trigger");

   // Comparator follows the selected channel one cycle later
   AST_SRC_ABOVE: assert property (
      ({1'b0, sel_sample} >= level_hi) |=> cmp_reg)
      else $error("comparator missed a sample above level plus band");

   AST_LEVEL_BELOW: assert property (
      (sel_sample < level_reg) |=> !cmp_reg)
      else $error("comparator missed a sample below level");

   AST_BAND_HOLD: assert property (
      (({1'b0, sel_sample} < level_hi) && (sel_sample >= level_reg)) |=> $stable(cmp_reg))
      else $error("comparator toggled inside the noise band");

   // Inhibit must run its full count even if a sync pulse arrives meanwhile
   AST_INHIBIT_HOLD: assert property (
      (user_run && state_reg == TVS_ST_INHIBIT && !inhibit_done) |=> state_reg == TVS_ST_INHIBIT)
      else $error("inhibit period cut short");

   AST_INHIBIT_END: assert property (
      (state_reg == TVS_ST_INHIBIT && inhibit_done) |=> state_reg == TVS_ST_SEEK_SYNC)
      else $error("sequencer did not return to sync search after inhibit");

   AST_MINWIDTH_REFUSE: assert property (
      (wr_minwidth && !minwidth_ok) |=> $stable(min_width_reg))
      else $error("out of range minimum width accepted");

   AST_EVCOUNT_RANGE: assert property (
      (ev_count_reg >= 24'(TVS_EVCOUNT_MIN)) && ({8'h00, ev_count_reg} <= 32'(EVCOUNT_MAX)))
      else $error("event count out of range");

   AST_WIDTH_READBACK: assert property (
      (reg_rd && reg_addr == TVS_OFS_MINWIDTH) |=> reg_rdata == {5'h00, $past(min_width_reg)})
      else $error("minimum width readback wrong");

   AST_DELAY_HOLD: assert property (
      (user_run && state_reg == TVS_ST_DELAY && !sync_lead) |=>
      (state_reg == TVS_ST_DELAY) && $stable(ev_prog_reg))
      else $error("delay count moved without a sync edge");

   AST_ARMED_LEVEL: assert property (
      armed_out == ((state_reg == TVS_ST_DELAY) || (state_reg == TVS_ST_EDGE)))
      else $error("armed output disagrees with sequencer state");

   // A disabled or standard-mode sequencer must stay silent
   AST_IDLE_NO_TRIG: assert property (
      !user_run |=> !trig_out)
      else $error("trigger while user mode is off");

   COV_ARMED: cover property (state_reg == TVS_ST_SEEK_SYNC ##1 state_reg == TVS_ST_DELAY);
   COV_TRIGGER: cover property (trig_out);
   COV_STD_QUAL: cover property (std_vsync_qual_out);
   COV_REFUSED: cover property (wr_evcount && !evcount_ok);
   COV_INHIBIT_END: cover property (state_reg == TVS_ST_INHIBIT ##1 state_reg == TVS_ST_SEEK_SYNC);

endmodule : tvs_trigger_sequencer

// [sim/tvs_chan_model.sv]
// Channel model: the selected channel carries timed sync pulses, the others
// toggle every cycle, so a wrong channel choice shows up as stray edges.
// Assumes the bench changes the controls right after a rising edge.
`timescale 1ns/1ps
module tvs_chan_model
   import tvs_pkg::*;
#(
   parameter int N_CHAN = 4,
   parameter int SAMPLE_W = 8
) (
   input wire logic ref_clk, // Sample clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic go, // Start a pulse
   input wire logic [7:0] len, // Pulse length in cycles
   input wire logic neg, // Low-going pulses on a high idle level
   input wire logic [SAMPLE_W-1:0] hi_val, // Sample value while high
   input wire logic [1:0] sel, // Channel carrying the pulses
   output logic [N_CHAN-1:0][SAMPLE_W-1:0] chan_sample // Samples to the sequencer
);
   logic [7:0] cnt_reg;
   logic flip_reg;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 8'h00;
         flip_reg <= 1'b0;
      end else begin
         flip_reg <= ~flip_reg;
         cnt_reg <= go ? len : (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
      end
   end
   // Unselected channels swing across any level every cycle
   always_comb begin
      for (int i = 0; i < N_CHAN; i++) begin
         if (i == int'(sel)) chan_sample[i] = ((cnt_reg != 8'h00) ^ neg) ? hi_val : SAMPLE_W'(8'h10);
         else chan_sample[i] = flip_reg ? '1 : '0;
      end
   end
endmodule : tvs_chan_model

// [sim/tv_sync_trigger_sequencer_tb.sv]
// Self-checking bench for the television trigger sequencer.
// Assumes the register port answers reads in the next cycle and short sim limits.
`timescale 1ns/1ps
module tv_sync_trigger_sequencer_tb;
   import tvs_pkg::*;
   localparam int LIM = 1000;
   logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
   logic [7:0] reg_addr = 8'h00, m_len = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
   logic go = 1'b0, m_neg = 1'b0, trig_out, armed_out, std_vsync_qual_out;
   logic [7:0] m_hi = 8'hF0;
   logic [1:0] m_sel = 2'h0;
   logic [3:0][7:0] chan_sample;
   logic [31:0] exp_q[$];
   int error_cnt = 0, cmp_count = 0, trig_cnt = 0, n;
   tvs_trigger_sequencer #(.MIN_WIDTH_MAX_CYC(LIM), .EVCOUNT_MAX(LIM)) dut (.ref_clk(ref_clk), .rst(rst),
      .chan_sample(chan_sample), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_out(trig_out), .armed_out(armed_out),
      .std_vsync_qual_out(std_vsync_qual_out));
   tvs_chan_model model (.ref_clk(ref_clk), .rst(rst), .go(go), .len(m_len), .neg(m_neg), .hi_val(m_hi),
      .sel(m_sel), .chan_sample(chan_sample));
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop;
      $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
         error_cnt++;
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a; exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic start_pulse(input logic [7:0] l, input logic [7:0] h);
      @(posedge ref_clk);
      go <= 1'b1; m_len <= l; m_hi <= h;
      @(posedge ref_clk);
      go <= 1'b0;
   endtask : start_pulse
   task automatic pulse(input logic [7:0] l);
      start_pulse(l, 8'hF0);
      repeat (int'(l) + 5) @(posedge ref_clk);
   endtask : pulse
   function automatic logic [31:0] mk(input logic u, input logic [1:0] ln, input logic sp, input logic up,
         input logic f, input logic [1:0] s);
      tvs_ctrl_t c;
      c = '0; c.user_mode = u; c.line_mode = ln; c.std_sync_positive = sp; c.user_sync_positive = up;
      c.trig_edge_falling = f; c.source_sel = s; c.enable = 1'b1;
      return c;
   endfunction : mk
   // Read data stands only in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (rd_seen) check(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
      if (trig_out === 1'b1) trig_cnt++;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'habb9));
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      rd(TVS_OFS_CTRL, TVS_CTRL_RESET);
      rd(TVS_OFS_LEVEL, TVS_LEVEL_RESET);
      rd(TVS_OFS_EVCOUNT, 32'(TVS_EVCOUNT_RESET));
      rd(TVS_OFS_MINWIDTH, 32'(TVS_MINWIDTH_RESET));
      rd(TVS_OFS_INHIBIT, TVS_INHIBIT_RESET);
      rd(8'h1C, 32'h0);
      wr(TVS_OFS_STATUS, 32'hFF);
      rd(TVS_OFS_STATUS, 32'h1);
      $display("test reset values done");
      wr(TVS_OFS_EVCOUNT, 32'h0);
      wr(TVS_OFS_EVCOUNT, LIM + 1);
      rd(TVS_OFS_EVCOUNT, 32'h1);
      wr(TVS_OFS_MINWIDTH, 32'h0);
      wr(TVS_OFS_MINWIDTH, LIM + 1);
      rd(TVS_OFS_MINWIDTH, 32'h1);
      for (int i = 0; i < 4; i++) begin
         v = $urandom_range(LIM, 1);
         wr(TVS_OFS_EVCOUNT, v);
         // Kept inside 1..LIM so the write is always accepted
         wr(TVS_OFS_MINWIDTH, (v - 32'h1) | 32'h1);
         rd(TVS_OFS_EVCOUNT, v);
         rd(TVS_OFS_MINWIDTH, (v - 32'h1) | 32'h1);
      end
      $display("test register ranges done");
      for (int ln = 0; ln < 3; ln++) begin
         for (int p = 0; p < 2; p++) begin
            wr(TVS_OFS_CTRL, mk(1'b0, 2'(ln), 1'(p), 1'b0, 1'b0, 2'h0));
            rd(TVS_OFS_CTRL, mk(1'b0, 2'(ln), 1'(p), 1'b0, 1'b0, 2'h0));
            repeat (4) @(posedge ref_clk);
            check(std_vsync_qual_out, (ln != 0) && (p == 0));
            start_pulse(8'd12, 8'hF0);
            repeat (4) @(posedge ref_clk);
            check(std_vsync_qual_out, (ln != 0) && (p == 1));
            repeat (12) @(posedge ref_clk);
         end
      end
      // Band above the level: 0x90 sits inside it, 0xA0 is its edge
      wr(TVS_OFS_LEVEL, 32'h0000_6040);
      for (int k = 0; k < 2; k++) begin
         start_pulse(8'd12, k ? 8'hA0 : 8'h90);
         repeat (4) @(posedge ref_clk);
         check(std_vsync_qual_out, k);
         repeat (12) @(posedge ref_clk);
      end
      wr(TVS_OFS_LEVEL, 32'h0000_0080);
      $display("test standard polarity done");
      for (int k = 0; k < 4; k++) begin
         @(posedge ref_clk);
         m_sel <= 2'(k); m_neg <= k[0];
         wr(TVS_OFS_CTRL, mk(1'b1, TVS_LINE_NONE, 1'b0, !k[0], k[1], 2'(k)));
         wr(TVS_OFS_MINWIDTH, 32'h3);
         wr(TVS_OFS_EVCOUNT, 32'h2);
         wr(TVS_OFS_INHIBIT, 32'd30);
         repeat (8) @(posedge ref_clk);
         n = trig_cnt;
         check(armed_out, 1'b0);
         pulse(8'd3);
         check(armed_out, 1'b0);
         pulse(8'd4);
         check(armed_out, 1'b1);
         pulse(8'd2);
         check(trig_cnt, n);
         rd(TVS_OFS_EVPROGRESS, 32'h1);
         pulse(8'd2);
         // An edge opposite to the sync lead ends this same pulse, so it fires here
         check(trig_cnt, n + (k[1] != k[0]));
         start_pulse(8'd8, 8'hF0);
         repeat (4) @(posedge ref_clk);
         check(trig_cnt, n + 1);
         repeat (9) @(posedge ref_clk);
         check(trig_cnt, n + 1);
         pulse(8'd6);
         check(armed_out, 1'b0);
         repeat (40) @(posedge ref_clk);
         check(trig_cnt, n + 1);
      end
      $display("test user sequences done");
      repeat (4) @(posedge ref_clk);
      check(exp_q.size(), 0);
      report_and_stop();
   end
endmodule : tv_sync_trigger_sequencer_tb
